/* File: dramc_ctrl.sv */
// controller driving the address multiplexer and refresh counter
`timescale 1ns/1ps
// What this block does
// - sample wrap flag after settle time
// - flip-flop counts two wraps for 128
// - one row per period over row count
// - pulse count once after each refresh
// - count only after address hold time
// - count input active low, one step
module dramc_ctrl
   import dramc_pkg::*;
#(
   parameter int unsigned ROW_INTERVAL = ROW_INTERVAL_CYC
) (
   // clock and reset
   input  wire logic              clock_in,
   input  wire logic              rst_in,
   // user side
   input  wire logic              burst_req_in,     // start a burst refresh
   input  wire logic              burst_long_in,    // high: 128-row burst, low: 64
   input  wire logic              dist_en_in,       // enable distributed refresh
   input  wire logic              access_req_in,    // normal access request
   input  wire logic [13:0]       access_addr_in,   // system address, row low half
   output logic                   busy_out,         // refresh in progress
   output logic                   ref_strobe_out,   // one refresh cycle strobe to memory
   output logic                   burst_done_out,   // one-cycle pulse at burst end
   // device pins
   input  wire logic              wrap_flag_n_in,   // active low wrap flag from device
   output dramc_pkg::dramc_pins_t pins_out          // select, count and address pins
);
   import dramc_pkg::*;

   // ***********************************************
   // state
   // ***********************************************
   // timers share one width; the row interval is the longest count
   dramc_state_t     state_q;         // sequencer state
   logic [TMR_W-1:0] tmr_q;           // step timer
   logic [TMR_W-1:0] row_tmr_q;       // distributed interval timer
   logic             dist_due_q;      // distributed row pending
   logic             in_burst_q;      // burst in progress
   logic             burst_long_q;    // burst length latched
   logic             wrap_seen_q;     // external wrap flip-flop
   logic             wrap_s1_q;       // wrap flag sync stage one
   logic             wrap_s2_q;       // wrap flag sync stage two
   logic             access_q;        // row half phase of access
   dramc_pins_t      pins_q;          // registered pin group

   // ***********************************************
   // synchroniser for the device flag
   // ***********************************************
   // two flops keep a metastable flag level away from the sequencer
   // reset to the idle level: flag high means counter not at zero
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         wrap_s1_q <= 1'b1;
         wrap_s2_q <= 1'b1;
      end else begin
         wrap_s1_q <= wrap_flag_n_in;
         wrap_s2_q <= wrap_s1_q;
      end
   end

   // ***********************************************
   // distributed refresh interval
   // ***********************************************
   // interval timer runs only while distributed refresh is on
   // one row per interval
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         row_tmr_q  <= '0;
         dist_due_q <= 1'b0;
      end else begin
         // turning the mode off restarts the interval
         if (!dist_en_in) begin
            row_tmr_q <= '0;
         end else if (row_tmr_q == TMR_W'(ROW_INTERVAL - 1)) begin
            row_tmr_q <= '0;
         end else begin
            row_tmr_q <= row_tmr_q + 1'b1;
         end
         // pending row is held until the sequencer takes it
         // set wins over the clear at sequence start
         if (dist_en_in && row_tmr_q == TMR_W'(ROW_INTERVAL - 1)) begin
            dist_due_q <= 1'b1;
         end else if (state_q == ST_IDLE && !in_burst_q && !burst_req_in) begin
            dist_due_q <= 1'b0;
         end
      end
   end

   // ***********************************************
   // refresh sequencer
   // ***********************************************
   // one row per pass: select, strobe, count, settle, check
   // a burst request while busy is ignored; wait for busy to fall
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         // idle pins: address mode, row half, count line high
         state_q        <= ST_IDLE;
         tmr_q          <= '0;
         in_burst_q     <= 1'b0;
         burst_long_q   <= 1'b0;
         wrap_seen_q    <= 1'b0;
         busy_out       <= 1'b0;
         ref_strobe_out <= 1'b0;
         burst_done_out <= 1'b0;
         access_q       <= 1'b0;
         pins_q         <= '{refresh_sel: 1'b0, row_sel: 1'b1, count_n: 1'b1,
                             row_addr: '0, col_addr: '0};
      end else begin
         // one-cycle pulses fall back by default
         burst_done_out <= 1'b0;
         ref_strobe_out <= 1'b0;
         // step timer runs freely, cleared at each step change except settle to check
         tmr_q          <= tmr_q + 1'b1;
         case (state_q)
            // idle: start a refresh or multiplex the system address
            ST_IDLE: begin
               pins_q.count_n <= 1'b1;
               if (burst_req_in || dist_due_q) begin
                  pins_q.refresh_sel <= 1'b1;
                  in_burst_q         <= burst_req_in;
                  burst_long_q       <= burst_long_in;
                  wrap_seen_q        <= 1'b0;
                  busy_out           <= 1'b1;
                  tmr_q              <= '0;
                  state_q            <= ST_SEL;
               end else begin
                  pins_q.refresh_sel <= 1'b0;
                  pins_q.row_addr    <= access_addr_in[ADDR_W-1:0];
                  pins_q.col_addr    <= access_addr_in[2*ADDR_W-1:ADDR_W];
                  if (access_req_in && !access_q) begin
                     pins_q.row_sel <= 1'b1;
                     access_q       <= 1'b1;
                  end else begin
                     pins_q.row_sel <= !access_q;
                     access_q       <= 1'b0;
                  end
               end
            end
            // wait for the counter address to reach the memory
            // the same wait serves every burst row
            ST_SEL: begin
               if (tmr_q == TMR_W'(ROW_SETTLE_CYC - 1)) begin
                  ref_strobe_out <= 1'b1;
                  tmr_q          <= '0;
                  state_q        <= ST_STROBE;
               end
            end
            // hold the row address past the strobe before counting
            // counting early would move the address under the memory
            ST_STROBE: begin
               if (tmr_q == TMR_W'(ADDR_HOLD_CYC - 1)) begin
                  pins_q.count_n <= 1'b0;
                  tmr_q          <= '0;
                  state_q        <= ST_CNT_LO;
               end
            end
            // count line low for the least pulse width
            ST_CNT_LO: begin
               if (tmr_q == TMR_W'(COUNT_PULSE_CYC - 1)) begin
                  pins_q.count_n <= 1'b1;
                  tmr_q          <= '0;
                  state_q        <= ST_SETTLE;
               end
            end
            // flag may spike after the count edge; do not look yet
            ST_SETTLE: begin
               // wait flag settle plus sync delay
               if (tmr_q == TMR_W'(WRAP_SETTLE_CYC + 1)) begin
                  state_q <= ST_CHECK;
               end
            end
            // decide: next row, burst end or back to idle
            ST_CHECK: begin
               tmr_q <= '0;
               if (!in_burst_q) begin
                  // distributed row: one row, then idle
                  state_q  <= ST_IDLE;
                  busy_out <= 1'b0;
               end else if (!wrap_s2_q && (!burst_long_q || wrap_seen_q)) begin
                  // one wrap ends 64 rows; two for 128
                  in_burst_q     <= 1'b0;
                  busy_out       <= 1'b0;
                  burst_done_out <= 1'b1;
                  state_q        <= ST_IDLE;
               end else begin
                  if (!wrap_s2_q) begin
                     wrap_seen_q <= 1'b1;
                  end
                  state_q <= ST_SEL;
               end
            end
            // unused codes return to idle
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ***********************************************
   // pin outputs
   // ***********************************************
   // pin group leaves straight from its register
   // device inverts; host drives true address
   assign pins_out = pins_q;
endmodule

/* File: dramc_ctrl_checker.sv */
// checker: timing relations on the controller pins
`timescale 1ns/1ps
module dramc_ctrl_checker
   import dramc_pkg::*;
(
   input wire logic                   clock_in,
   input wire logic                   rst_in,
   input wire logic                   busy_out,
   input wire logic                   ref_strobe_out,
   input wire logic                   burst_done_out,
   input wire dramc_pkg::dramc_pins_t pins_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   hold_then_count_a: assert property (
      ref_strobe_out |-> ##2 $fell(pins_out.count_n)) else $error("count pulse not after hold");
   pulse_width_a: assert property (
      $fell(pins_out.count_n) |=> !pins_out.count_n ##1 pins_out.count_n) else $error("count width");
   count_in_refresh_a: assert property (
      !pins_out.count_n |-> pins_out.refresh_sel && busy_out) else $error("count outside refresh");
   settle_wait_a: assert property (
      $rose(pins_out.count_n) |-> !(ref_strobe_out || burst_done_out) [*5]) else $error("flag used early");
   burst_end_a: assert property (
      burst_done_out |-> !busy_out) else $error("busy after burst end");
   row_start_a: assert property (
      $rose(pins_out.refresh_sel) |-> busy_out ##2 ref_strobe_out) else $error("row start timing");
   cover property (burst_done_out);
   cover property (ref_strobe_out);
   cover property ($fell(pins_out.count_n));
endmodule
bind dramc_ctrl dramc_ctrl_checker chk (.clock_in(clock_in), .rst_in(rst_in), .busy_out(busy_out),
   .ref_strobe_out(ref_strobe_out), .burst_done_out(burst_done_out), .pins_out(pins_out));

/* File: dramc_ctrl_test.sv */
// self-checking bench for the refresh controller
`timescale 1ns/1ps
module dramc_ctrl_test;
   import dramc_pkg::*;
   logic        clock_in = 0, rst_in = 1, burst_req, burst_long, dist_en, access_req;
   logic [13:0] addr;
   logic        busy, strobe, done, wrap_n;
   logic [6:0]  mem_n;
   dramc_pins_t pins;
   int          miscompares = 0, cmp_count = 0, cycles = 0, cnt = 'h3A, n = 0, w, e;
   bit          lens[3] = '{0, 1, 0};
   dramc_ctrl #(.ROW_INTERVAL(50)) dut (.clock_in(clock_in), .rst_in(rst_in),
      .burst_req_in(burst_req), .burst_long_in(burst_long), .dist_en_in(dist_en),
      .access_req_in(access_req), .access_addr_in(addr), .busy_out(busy), .ref_strobe_out(strobe),
      .burst_done_out(done), .wrap_flag_n_in(wrap_n), .pins_out(pins));
   dramc_dev_model #(.START(7'h3A)) dev (.pins_in(pins), .mem_addr_out_n(mem_n), .wrap_flag_n_out(wrap_n));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected value at %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial forever #10 clock_in = ~clock_in;
   // hang guard
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 10000) begin
         miscompares++;
         close_out();
      end
   end
   // counter model: each strobe refreshes row cnt, then steps it
   always @(negedge clock_in) if (strobe === 1'b1) begin
      check(mem_n, 7'(~cnt[6:0]));
      cnt = (cnt + 1) % 128;
      n++;
   end
   initial begin
      burst_req = 0; burst_long = 0; dist_en = 0; access_req = 0; addr = 14'h0000;
      void'($urandom(32'h7C37E82B));
      repeat (20) @(negedge clock_in);
      rst_in = 0;
      repeat (8) begin
         addr = 14'($urandom);
         access_req = 1;
         repeat (3 + $urandom % 3) @(negedge clock_in);
         check(mem_n, 7'(~(pins.row_sel ? addr[6:0] : addr[13:7])));
         check({pins.row_addr, pins.col_addr}, {addr[6:0], addr[13:7]});
      end
      access_req = 0;
      repeat (4) @(negedge clock_in);
      foreach (lens[i]) begin
         burst_long = lens[i];
         n = 0;
         e = 64 - cnt % 64 + (lens[i] ? 64 : 0);
         burst_req = 1;
         @(negedge clock_in);
         burst_req = 0;
         w = 0;
         while (done !== 1'b1 && w < 3000) begin
            @(negedge clock_in);
            w++;
         end
         check(done, 1'b1);
         check(n, e);
         @(negedge clock_in);
         check(busy, 1'b0);
      end
      n = 0;
      dist_en = 1;
      repeat (300) @(negedge clock_in);
      dist_en = 0;
      check(n >= 5 && n <= 7, 1'b1);
      repeat (40) @(negedge clock_in);
      close_out();
   end
endmodule

/* File: dramc_dev_model.sv */
// behavioural model of the address multiplexer and refresh counter
`timescale 1ns/1ps
module dramc_dev_model
   import dramc_pkg::*;
#(
   parameter logic [6:0] START     = 7'h3A,   // counter has no reset value
   parameter int         SETTLE_NS = 70       // wrap flag settling time
) (
   input  wire dramc_pkg::dramc_pins_t pins_in,
   output logic [6:0]                  mem_addr_out_n,
   output logic                        wrap_flag_n_out
);
   logic [6:0] cnt_q  = START;   // refresh row counter
   logic       glitch = 1'b0;    // flag not yet settled
   always @(negedge pins_in.count_n) begin
      cnt_q = cnt_q + 7'h01;
      glitch = 1'b1;
      #(SETTLE_NS) glitch = 1'b0;
   end
   assign wrap_flag_n_out = glitch ^ (cnt_q[5:0] != 6'h00);
   assign mem_addr_out_n = ~(pins_in.refresh_sel ? cnt_q :
                             pins_in.row_sel ? pins_in.row_addr : pins_in.col_addr);
endmodule

/* File: dramc_pkg.sv */
// package: timing constants, pin groups and states for the refresh controller
package dramc_pkg;
   // ***********************************************
   // clock and timing
   // ***********************************************
   localparam int unsigned CLK_PERIOD_NS        = 20;        // 50 MHz system clock
   localparam int unsigned WRAP_SETTLE_NS       = 70;        // wrap flag settling time, longest
   localparam int unsigned WRAP_SETTLE_CYC      = (WRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned COUNT_PULSE_NS       = 35;        // least count pulse width
   localparam int unsigned COUNT_PULSE_CYC      = (COUNT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ADDR_HOLD_NS         = 40;        // memory address hold before count
   localparam int unsigned ADDR_HOLD_CYC        = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned REFRESH_PERIOD_MS    = 2;         // memory refresh period
   localparam int unsigned REFRESH_ROWS         = 128;       // refresh cycles per period
   localparam int unsigned ROW_INTERVAL_CYC     =
      (REFRESH_PERIOD_MS * 1000000 / CLK_PERIOD_NS) / REFRESH_ROWS;
   localparam int unsigned ROW_SETTLE_CYC       = 2;         // select to output settle before strobe
   localparam int unsigned TMR_W                = 16;        // timer width
   localparam int unsigned ADDR_W               = 7;         // half address width

   // ***********************************************
   // pin groups
   // ***********************************************
   typedef struct packed {
      logic             refresh_sel;   // high: counter drives outputs
      logic             row_sel;       // high: row half, low: column half
      logic             count_n;       // active low count pulse
      logic [ADDR_W-1:0] row_addr;     // row half of address
      logic [ADDR_W-1:0] col_addr;     // column half of address
   } dramc_pins_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SEL, ST_STROBE, ST_CNT_LO, ST_SETTLE, ST_CHECK
   } dramc_state_t;
endpackage
